// ==== logic/adc_out_pkg.sv ====
// Constants shared by the serial output configuration block
package adc_out_pkg;
	// ****************************************************************
	// Register map of the serial control port
	// ****************************************************************
	localparam logic [7:0] CLOCK_REFERENCE_PHASE_CONTROL_ADDR = 8'h42;
	localparam logic [7:0] OUTPUT_FORMAT_CONTROL_ADDR = 8'h46;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam int CTL_WORD_BITS = 24;
	// Fields of the clock, reference and phase register
	localparam int BALANCED_CLOCK_BIT = 0;
	localparam int DUTY_CORRECTION_BIT = 2;
	localparam int CM_REF_INPUT_BIT = 3;
	localparam int DDR_PHASE_LSB = 5;
	localparam int PARTIAL_PD_BIT = 10;
	// Fields of the output format register
	localparam int TWOS_COMPLEMENT_BIT = 2;
	localparam int MSB_FIRST_BIT = 3;
	localparam int SINGLE_RATE_BIT = 4;
	localparam int SINGLE_RATE_EDGE_BIT = 13;
	// ****************************************************************
	// Serial link geometry
	// ****************************************************************
	localparam int CHANNELS = 8;
	localparam int WORD_BITS = 12;
	localparam logic [3:0] LAST_BIT = 4'hB;
	localparam logic [3:0] FRAME_HIGH_BITS = 4'h6;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_MHZ = 125;
	localparam int FULL_WAKE_US = 50;
	localparam int PARTIAL_WAKE_US = 2;
	localparam int FULL_WAKE_CYC = FULL_WAKE_US * CLK_MHZ;
	localparam int PARTIAL_WAKE_CYC = PARTIAL_WAKE_US * CLK_MHZ;
	localparam int CLK_LOST_CYC = 64;
	localparam int WAKE_W = 16;
endpackage : adc_out_pkg

// ==== logic/adc_serial_output_config.sv ====
// Serial output formatter and configuration for an eight-channel ADC
`timescale 1ns/1ns
module adc_serial_output_config #(
	parameter int FULL_WAKE_CYCLES = adc_out_pkg::FULL_WAKE_CYC
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ctl_enable_b,
	input wire logic ctl_clock,
	input wire logic ctl_data,
	input wire logic sample_clock_pos,
	input wire logic sample_clock_neg,
	input wire logic reference_source_pin,
	input wire logic converter_powerdown_pin,
	input wire logic [7:0][11:0] sample_word,
	output logic [7:0] serial_data,
	output logic serial_bit_clock,
	output logic word_frame_clock,
	output logic converter_ready,
	output logic balanced_clock_select,
	output logic duty_correction_enable,
	output logic external_reference_active,
	output logic common_mode_pin_oe
);
	// ****************************************************************
	// Reset release and input synchronisers
	// ****************************************************************
	logic [1:0] rst_sync_r;
	logic rst_n;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// Pins: enable, clock, data, clk pos, clk neg, ref pin, powerdown
	logic [6:0] pin_meta_r;
	logic [6:0] pin_r;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_r <= 7'h21;
			pin_r <= 7'h21;
		end else begin
			pin_meta_r <= {converter_powerdown_pin, reference_source_pin,
				sample_clock_neg, sample_clock_pos, ctl_data, ctl_clock,
				ctl_enable_b};
			pin_r <= pin_meta_r;
		end
	end

	// ****************************************************************
	// Serial control port: 8 address bits then 16 data bits, MSB first
	// ****************************************************************
	logic ctl_clock_d_r;
	logic [23:0] ctl_shift_r;
	logic [4:0] ctl_count_r;
	logic [15:0] clock_reference_phase_control_r;
	logic [15:0] output_format_control_r;
	logic ctl_rise;
	logic ctl_done;
	assign ctl_rise = pin_r[1] && !ctl_clock_d_r && !pin_r[0];
	assign ctl_done = ctl_rise &&
		(ctl_count_r == 5'(adc_out_pkg::CTL_WORD_BITS - 1));

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_clock_d_r <= 1'b0;
			ctl_shift_r <= 24'h000000;
			ctl_count_r <= 5'h00;
		end else begin
			ctl_clock_d_r <= pin_r[1];
			if (pin_r[0]) begin
				ctl_count_r <= 5'h00;
			end else if (ctl_rise) begin
				ctl_shift_r <= {ctl_shift_r[22:0], pin_r[2]};
				ctl_count_r <= ctl_done ? 5'h00 : ctl_count_r + 5'h01;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			clock_reference_phase_control_r <= adc_out_pkg::REG_RESET;
			output_format_control_r <= adc_out_pkg::REG_RESET;
		end else if (ctl_done) begin
			if (ctl_shift_r[22:15] ==
				adc_out_pkg::CLOCK_REFERENCE_PHASE_CONTROL_ADDR) begin
				clock_reference_phase_control_r <=
					{ctl_shift_r[14:0], pin_r[2]};
			end
			if (ctl_shift_r[22:15] == adc_out_pkg::OUTPUT_FORMAT_CONTROL_ADDR) begin
				output_format_control_r <= {ctl_shift_r[14:0], pin_r[2]};
			end
		end
	end

	// ****************************************************************
	// Clock and reference configuration outputs
	// ****************************************************************
	logic balanced;
	assign balanced =
		clock_reference_phase_control_r[adc_out_pkg::BALANCED_CLOCK_BIT];
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			balanced_clock_select <= 1'b0;
			duty_correction_enable <= 1'b0;
			external_reference_active <= 1'b0;
			common_mode_pin_oe <= 1'b1;
		end else begin
			balanced_clock_select <= balanced;
			duty_correction_enable <= clock_reference_phase_control_r[
				adc_out_pkg::DUTY_CORRECTION_BIT];
			external_reference_active <= !pin_r[5];
			// CM stops being driven only when it must act as the reference input
			common_mode_pin_oe <= !(!pin_r[5] &&
				clock_reference_phase_control_r[
				adc_out_pkg::CM_REF_INPUT_BIT]);
		end
	end

	// ****************************************************************
	// Sample clock activity, needed to judge partial-power-down wake
	// ****************************************************************
	logic samp_level;
	logic samp_d_r;
	logic [6:0] idle_count_r;
	logic clock_lost_r;
	// Single-ended uses only the positive pin; balanced compares both
	assign samp_level = balanced ? (pin_r[3] && !pin_r[4]) : pin_r[3];
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			samp_d_r <= 1'b0;
			idle_count_r <= 7'h00;
			clock_lost_r <= 1'b0;
		end else begin
			samp_d_r <= samp_level;
			if (samp_level != samp_d_r) begin
				idle_count_r <= 7'h00;
			end else if (idle_count_r !=
				7'(adc_out_pkg::CLK_LOST_CYC)) begin
				idle_count_r <= idle_count_r + 7'h01;
			end
			clock_lost_r <= idle_count_r == 7'(adc_out_pkg::CLK_LOST_CYC);
		end
	end

	// ****************************************************************
	// Power-down and wake sequencing
	// ****************************************************************
	logic [adc_out_pkg::WAKE_W-1:0] wake_count_r;
	logic stopped_in_pd_r;
	logic partial_sel;
	assign partial_sel =
		clock_reference_phase_control_r[adc_out_pkg::PARTIAL_PD_BIT];
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wake_count_r <= '0;
			stopped_in_pd_r <= 1'b0;
			converter_ready <= 1'b0;
		end else if (pin_r[6]) begin
			converter_ready <= 1'b0;
			stopped_in_pd_r <= stopped_in_pd_r || clock_lost_r;
			// A stopped clock forfeits the short wake, so full time applies
			if (partial_sel && !(stopped_in_pd_r || clock_lost_r)) begin
				wake_count_r <= adc_out_pkg::WAKE_W'(
					adc_out_pkg::PARTIAL_WAKE_CYC - 1);
			end else begin
				wake_count_r <= adc_out_pkg::WAKE_W'(
					FULL_WAKE_CYCLES - 1);
			end
		end else begin
			stopped_in_pd_r <= 1'b0;
			if (wake_count_r != '0) begin
				wake_count_r <= wake_count_r - 1'b1;
			end
			converter_ready <= wake_count_r == '0;
		end
	end

	// ****************************************************************
	// Serializer: two clocks per bit, twelve bits per word
	// ****************************************************************
	logic sub_r;
	logic [3:0] bit_r;
	logic [7:0][11:0] word_r;
	logic msb_first_r;
	logic single_rate_r;
	logic fall_edge_r;
	logic [1:0] phase_r;
	logic [1:0] quarter;
	logic [1:0] ddr_pos;
	logic word_end;
	assign word_end = sub_r && (bit_r == adc_out_pkg::LAST_BIT);
	assign quarter = {bit_r[0], sub_r};
	assign ddr_pos = quarter + 2'h3 + phase_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sub_r <= 1'b0;
			bit_r <= 4'h0;
		end else if (!converter_ready) begin
			sub_r <= 1'b0;
			bit_r <= 4'h0;
		end else begin
			sub_r <= !sub_r;
			if (sub_r) begin
				bit_r <= word_end ? 4'h0 : bit_r + 4'h1;
			end
		end
	end

	// Settings are sampled only at word boundaries or while not ready, so no word is torn
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			msb_first_r <= 1'b0;
			single_rate_r <= 1'b0;
			fall_edge_r <= 1'b0;
			phase_r <= 2'h0;
		end else if (word_end || !converter_ready) begin
			msb_first_r <= output_format_control_r[
				adc_out_pkg::MSB_FIRST_BIT];
			single_rate_r <= output_format_control_r[
				adc_out_pkg::SINGLE_RATE_BIT];
			fall_edge_r <= output_format_control_r[
				adc_out_pkg::SINGLE_RATE_EDGE_BIT];
			phase_r <= clock_reference_phase_control_r[
				adc_out_pkg::DDR_PHASE_LSB +: 2];
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < adc_out_pkg::CHANNELS; ch++) begin : g_lane
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					word_r[ch] <= 12'h000;
				end else if (word_end || !converter_ready) begin
					word_r[ch] <= sample_word[ch] ^ {output_format_control_r[
						adc_out_pkg::TWOS_COMPLEMENT_BIT], 11'h000};
				end
			end
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					serial_data[ch] <= 1'b0;
				end else if (!converter_ready) begin
					serial_data[ch] <= 1'b0;
				end else if (msb_first_r) begin
					serial_data[ch] <= word_r[ch][adc_out_pkg::LAST_BIT - bit_r];
				end else begin
					serial_data[ch] <= word_r[ch][bit_r];
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			serial_bit_clock <= 1'b0;
			word_frame_clock <= 1'b0;
		end else if (!converter_ready) begin
			serial_bit_clock <= 1'b0;
			word_frame_clock <= 1'b0;
		end else begin
			word_frame_clock <= bit_r < adc_out_pkg::FRAME_HIGH_BITS;
			if (single_rate_r) begin
				serial_bit_clock <= sub_r ^ fall_edge_r;
			end else begin
				serial_bit_clock <= ddr_pos[1];
			end
		end
	end
endmodule : adc_serial_output_config

// ==== verification/adc_output_checker_properties.sv ====
// Port-level checks for the serial output configuration block
`timescale 1ns/1ns
module adc_output_checker #(
	parameter int FULL_WAKE_CYCLES = 40
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic reference_source_pin,
	input wire logic converter_powerdown_pin,
	input wire logic [7:0] serial_data,
	input wire logic serial_bit_clock,
	input wire logic word_frame_clock,
	input wire logic converter_ready,
	input wire logic external_reference_active,
	input wire logic common_mode_pin_oe
);
	// Partial wake is a fixed 250 cycles, so it may be the longer bound
	localparam int WMAX = (FULL_WAKE_CYCLES > 250 ? FULL_WAKE_CYCLES : 250) + 12;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	sequence pd_held;
		converter_powerdown_pin [*6];
	endsequence
	sequence asleep;
		!converter_ready [*2];
	endsequence
	chk_frame_high_len: assert property (
		$rose(word_frame_clock) |-> ##12
		($fell(word_frame_clock) || !converter_ready))
		else $error("frame high");
	chk_frame_low_len: assert property (
		$fell(word_frame_clock) |-> ##12
		($rose(word_frame_clock) || !converter_ready))
		else $error("frame low");
	chk_bit_two_cycles: assert property (
		$rose(word_frame_clock) |=>
		($stable(serial_data) || !converter_ready)) else $error("bit width");
	chk_link_quiet: assert property (
		asleep |-> serial_data == 8'h00 &&
		!word_frame_clock && !serial_bit_clock) else $error("link not quiet");
	chk_ext_ref_on: assert property (!reference_source_pin [*8] |->
		external_reference_active) else $error("ext ref not on");
	chk_ext_ref_off: assert property (reference_source_pin [*8] |->
		!external_reference_active) else $error("ext ref not off");
	chk_cm_pin_input: assert property (!common_mode_pin_oe |->
		external_reference_active || $past(external_reference_active))
		else $error("cm pin released");
	chk_wake_bound: assert property (
		$fell(converter_powerdown_pin) |->
		##[1:WMAX] (converter_ready || converter_powerdown_pin))
		else $error("wake late");
	chk_pd_sleeps: assert property (pd_held |-> !converter_ready)
		else $error("ready in power-down");
endmodule : adc_output_checker
bind adc_serial_output_config adc_output_checker #(
	.FULL_WAKE_CYCLES(FULL_WAKE_CYCLES)
) checks (.mclk, .rst_b, .reference_source_pin, .converter_powerdown_pin,
	.serial_data, .serial_bit_clock, .word_frame_clock, .converter_ready,
	.external_reference_active, .common_mode_pin_oe);

// ==== verification/lane_receiver_model.sv ====
// Receiving end of the serial link: rebuilds each lane's word
`timescale 1ns/1ns
module lane_receiver_model (
	input wire logic mclk,
	input wire logic [7:0] serial_data,
	input wire logic word_frame_clock,
	output logic [7:0][11:0] rx_word
);
	logic frame_q = 1'b0;
	logic [4:0] pos = 5'h00;
	logic [7:0][11:0] acc;
	always_ff @(posedge mclk) begin
		frame_q <= word_frame_clock;
		if (word_frame_clock && !frame_q) begin
			pos <= 5'h01;
			// Only a word seen from its first bit is handed on
			if (pos == 5'h18)
				rx_word <= acc;
		end else begin
			pos <= pos + 5'h01;
			// Late sample keeps clear of the bit edges
			if (pos[0])
				for (int l = 0; l < 8; l++)
					acc[l] <= {serial_data[l], acc[l][11:1]};
		end
	end
endmodule : lane_receiver_model

// ==== verification/adc_serial_output_config_bench.sv ====
// Self-checking bench for the serial output configuration block
`timescale 1ns/1ns
module adc_serial_output_config_bench;
	localparam int WAKE = 40;
	localparam logic [7:0] CA = adc_out_pkg::CLOCK_REFERENCE_PHASE_CONTROL_ADDR;
	localparam logic [7:0] FA = adc_out_pkg::OUTPUT_FORMAT_CONTROL_ADDR;
	// Phase-0 bit clock per quarter: falls mid even bit, rises mid odd bit
	localparam logic [3:0] DDR_SHAPE = 4'h9;
	logic mclk = 1'b0, rst_b = 1'b0, ctl_enable_b = 1'b1, ctl_clock = 1'b0;
	logic ctl_data = 1'b0, sample_clock_pos = 1'b0, sample_clock_neg;
	logic reference_source_pin = 1'b1, converter_powerdown_pin = 1'b0;
	logic samp_run = 1'b1;
	logic [7:0][11:0] sample_word, rx_word;
	logic [7:0] serial_data;
	logic serial_bit_clock, word_frame_clock, converter_ready;
	logic balanced_clock_select, duty_correction_enable;
	logic external_reference_active, common_mode_pin_oe;
	int err_total = 0, n_compared = 0;
	assign sample_clock_neg = ~sample_clock_pos;
	initial forever #4 mclk = ~mclk;
	initial forever #80 sample_clock_pos = samp_run & ~sample_clock_pos;
	adc_serial_output_config #(.FULL_WAKE_CYCLES(WAKE)) uut (.mclk, .rst_b,
		.ctl_enable_b, .ctl_clock, .ctl_data, .sample_clock_pos,
		.sample_clock_neg, .reference_source_pin, .converter_powerdown_pin,
		.sample_word, .serial_data, .serial_bit_clock, .word_frame_clock,
		.converter_ready, .balanced_clock_select, .duty_correction_enable,
		.external_reference_active, .common_mode_pin_oe);
	lane_receiver_model far_end (.mclk, .serial_data, .word_frame_clock,
		.rx_word);
	// ****************************************************************
	// Access and comparison tasks
	// ****************************************************************
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc
	task automatic finish_test;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	task automatic check(input logic [11:0] got, exp, input string what);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
		end
	endtask : check
	// Clock high and low phases of 4 cycles clear the 3-cycle minimum
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		ctl_enable_b = 1'b0;
		cyc(4);
		for (int i = 23; i >= 0; i--) begin
			ctl_data = i > 15 ? a[i - 16] : d[i];
			cyc(4);
			ctl_clock = 1'b1;
			cyc(4);
			ctl_clock = 1'b0;
		end
		cyc(4);
		ctl_enable_b = 1'b1;
		cyc(8);
	endtask : wr
	task automatic rise;
		int k;
		k = 0;
		while (word_frame_clock !== 1'b0 && k < 30) begin
			cyc(1);
			k++;
		end
		// A frame stuck high must not slip through as a found rise
		if (word_frame_clock !== 1'b0)
			k = 60;
		while (word_frame_clock !== 1'b1 && k < 60) begin
			cyc(1);
			k++;
		end
		if (k >= 60 || word_frame_clock !== 1'b1) begin
			err_total++;
			finish_test();
		end
	endtask : rise
	task automatic rate(input logic [11:0] exp);
		logic [11:0] n;
		logic b;
		n = 12'h000;
		b = serial_bit_clock;
		repeat (24) begin
			cyc(1);
			if (serial_bit_clock !== b)
				n = n + 12'h001;
			b = serial_bit_clock;
		end
		check(n, exp, "bit clock rate");
	endtask : rate
	task automatic wake(input logic [15:0] cfg, input int lo, hi);
		int k;
		wr(CA, cfg);
		converter_powerdown_pin = 1'b1;
		cyc(20);
		check(converter_ready, 1'b0, "asleep");
		converter_powerdown_pin = 1'b0;
		k = 0;
		while (converter_ready !== 1'b1 && k < hi) begin
			cyc(1);
			k++;
		end
		check(12'(k >= lo && k < hi), 12'h001, "wake time");
	endtask : wake
	function automatic logic [11:0] fmt(input logic [11:0] s, input int m);
		logic [11:0] r;
		logic [11:0] v;
		r = s ^ {m[0], 11'h000};
		v = r;
		if (m[1])
			for (int i = 0; i < 12; i++)
				v[i] = r[11 - i];
		return v;
	endfunction : fmt
	initial begin
		for (int l = 0; l < 8; l++)
			sample_word[l] = 12'h8C1 ^ 12'(l * 37);
		cyc(6);
		rst_b = 1'b1;
		check(balanced_clock_select, 1'b0, "reset clk");
		check(common_mode_pin_oe, 1'b1, "reset cm");
		for (int m = 0; m < 4; m++) begin
			wr(FA, 16'(m << 2));
			rise();
			rise();
			rise();
			cyc(2);
			for (int l = 0; l < 8; l++)
				check(rx_word[l], fmt(sample_word[l], m), "word");
		end
		for (int p = 0; p < 4; p++) begin
			wr(CA, 16'(p << 5) | 16'h0005);
			rise();
			rise();
			check(serial_bit_clock, 12'(DDR_SHAPE[p]), "phase");
			cyc(1);
			check(serial_bit_clock, 12'(DDR_SHAPE[(p + 1) % 4]), "phase");
			rate(12'h00C);
		end
		check(balanced_clock_select, 1'b1, "balanced_clock_select");
		check(duty_correction_enable, 1'b1, "dcc");
		wr(8'h43, 16'h0000);
		check(balanced_clock_select, 1'b1, "unmapped");
		for (int e = 0; e < 2; e++) begin
			wr(FA, e ? 16'h2010 : 16'h0010);
			rise();
			rise();
			check(serial_bit_clock, 12'(e), "sdr edge");
			rate(12'h018);
		end
		wr(FA, 16'h0000);
		wr(CA, 16'h0008);
		reference_source_pin = 1'b0;
		cyc(8);
		check(external_reference_active, 1'b1, "ext ref");
		check(common_mode_pin_oe, 1'b0, "cm input");
		reference_source_pin = 1'b1;
		cyc(8);
		check(common_mode_pin_oe, 1'b1, "cm output");
		wake(16'h0000, WAKE, WAKE + 10);
		wake(16'h0400, 250, 260);
		// A sample clock stopped before power-down forfeits the short wake
		samp_run = 1'b0;
		wake(16'h0400, WAKE, WAKE + 10);
		samp_run = 1'b1;
		finish_test();
	end
endmodule : adc_serial_output_config_bench
